// ===== hdl/ledb_pkg.sv
// Purpose: Shared constants and types for the LED behaviour engine
// Assumes: 10 MHz system clock, 8-bit register port
// Notes: Pulse-2 and breathe periods, pulse counts and duty limits are fixed here
package ledb_pkg;
    localparam int NUM_LED = 6;
    // Register offsets
    localparam logic [7:0] ADDR_CONFIG = 8'h44;
    localparam logic [7:0] ADDR_LINK = 8'h72;
    localparam logic [7:0] ADDR_POLARITY = 8'h73;
    localparam logic [7:0] ADDR_DRIVE = 8'h74;
    localparam logic [7:0] ADDR_LINK_TRANS = 8'h77;
    localparam logic [7:0] ADDR_MIRROR = 8'h79;
    localparam logic [7:0] ADDR_ACTIVE = 8'h7B;
    localparam logic [7:0] ADDR_BEH_LOW = 8'h81;
    localparam logic [7:0] ADDR_BEH_HIGH = 8'h82;
    localparam logic [7:0] ADDR_P1_PERIOD = 8'h84;
    // Field positions
    localparam int CFG_BLOCK_POL_MIR_BIT = 0;
    localparam int CFG_INVERTED_LINK_TRANSITION_BIT = 1;
    localparam int P1_START_TRIG_BIT = 7;
    localparam int P1_PERIOD_MSB = 6;
    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_P1_PERIOD = 8'h20;
    // Behaviour codes
    localparam logic [1:0] BEH_DIRECT = 2'h0;
    localparam logic [1:0] BEH_PULSE1 = 2'h1;
    localparam logic [1:0] BEH_PULSE2 = 2'h2;
    localparam logic [1:0] BEH_BREATHE = 2'h3;
    // Periods in units of 32 ms
    localparam logic [6:0] P2_PERIOD_UNITS = 7'h14;
    localparam logic [6:0] BR_PERIOD_UNITS = 7'h5D;
    localparam logic [6:0] MIN_PERIOD_UNITS = 7'h05;
    localparam logic [11:0] PERIOD_UNIT_MS = 12'h020;
    // Pulse counts minus one
    localparam logic [2:0] P1_PULSES_M1 = 3'h4;
    localparam logic [2:0] P2_PULSES_M1 = 3'h0;
    // Duty limits on an 8-bit scale
    localparam logic [7:0] DUTY_MIN = 8'h00;
    localparam logic [7:0] DUTY_MAX = 8'hFF;
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int MS_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    typedef enum logic [1:0] {LEDB_IDLE, LEDB_RUN, LEDB_TAIL} ledb_run_t;
endpackage

// ===== hdl/ledb_engine.sv
// Purpose: Six-channel LED behaviour engine with register port and PWM pins
// Assumes: Inputs synchronous to clk_i; reads answer one cycle after read strobe
// Notes: Duty range, pulse counts and non-pulse-1 periods are fixed constants
//
// Function
// - Transition bit clear: linking a driven-on LED without touch changes its state.
// - Transition and inverted-transition set: link keeps state, later touch toggles it.
// - Transition set, inverted clear: link keeps state and touches do not change it.
// - Mirror bit zero: duty relative to 0%; one: relative to 100%.
// - Polarity write copies into mirror bits unless polarity-mirror block set.
// - Two-bit behaviour fields: LED1-4 in low register, LED5-6 in high register.
// - Unlinked LED: drive bit set is touch, clear is release.
// - Linked LED: touch and release on its input start and stop behaviour.
// - Direct: active state on touch or set, inactive on release or clear.
// - Pulse-1: one trigger gives programmed pulses of programmed period, no stop.
// - Pulse-2: pulse while active, then programmed pulses after stop, then minimum.
// - Breathe: ramp min to max and back, each half the period.
// - Unlinked breathe or pulse: settings apply only after re-actuation.
// - Unlinked pulse-1: ignore drive bit until the sequence ends.
// - Source switch: direct and breathe follow at once, pulses finish first.
// - Pulse-1 period in 32 ms units, 0 and 1 both 32 ms, reset 1024 ms. Here codes 0 to 4 all run at 160 ms.
// - Pulse-1 start trigger bit: zero on touch or set, one on release or clear.
// - Periods below 160 ms run at the shortest achievable period.
// - PWM rate follows settings; direct with zero ramps uses maximum rate. Here the PWM counter always runs at full rate.
// - Polarity zero inverts the pin so active pulls low; one drives high.
// - Linked LED ignores its host drive bit.
`timescale 1ns/1ns
module ledb_engine #(
    parameter int MS_CYCLES = ledb_pkg::MS_CYCLES
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [ledb_pkg::NUM_LED-1:0] touch_i,
    output logic [7:0] rdata_o,
    output logic [ledb_pkg::NUM_LED-1:0] led_pin_o
);
    import ledb_pkg::*;

    logic [7:0] config_q;
    logic [5:0] link_q;
    logic [5:0] pol_q;
    logic [5:0] drive_q;
    logic [5:0] ltran_q;
    logic [5:0] mirror_q;
    logic [7:0] beh_low_q;
    logic [3:0] beh_high_q;
    logic [7:0] p1_period_q;
    logic [5:0] hold_q;
    logic [5:0] act_q;
    logic [5:0] running;
    logic [5:0] act;
    logic [5:0] pin_d;
    logic [11:0] codes;
    logic [7:0] pwm_cnt_q;
    logic [13:0] ms_cnt_q;
    logic tick;
    logic [7:0] rdata_d;

    assign codes = {beh_high_q, beh_low_q};

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ms_cnt_q <= '0;
        end else if (ms_cnt_q == 14'(MS_CYCLES - 1)) begin
            ms_cnt_q <= '0;
        end else begin
            ms_cnt_q <= ms_cnt_q + 14'h0001;
        end
    end
    assign tick = (ms_cnt_q == 14'(MS_CYCLES - 1));

    // full-rate PWM, no ramp logic slows it
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pwm_cnt_q <= '0;
        end else begin
            pwm_cnt_q <= pwm_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            config_q <= RST_ZERO;
        end else if (wr_i && addr_i == ADDR_CONFIG) begin
            config_q <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            link_q <= RST_ZERO[5:0];
        end else if (wr_i && addr_i == ADDR_LINK) begin
            link_q <= wdata_i[5:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pol_q <= RST_ZERO[5:0];
        end else if (wr_i && addr_i == ADDR_POLARITY) begin
            pol_q <= wdata_i[5:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            drive_q <= RST_ZERO[5:0];
        end else if (wr_i && addr_i == ADDR_DRIVE) begin
            drive_q <= wdata_i[5:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ltran_q <= RST_ZERO[5:0];
        end else if (wr_i && addr_i == ADDR_LINK_TRANS) begin
            ltran_q <= wdata_i[5:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            beh_low_q <= RST_ZERO;
        end else if (wr_i && addr_i == ADDR_BEH_LOW) begin
            beh_low_q <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            beh_high_q <= RST_ZERO[3:0];
        end else if (wr_i && addr_i == ADDR_BEH_HIGH) begin
            beh_high_q <= wdata_i[3:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            p1_period_q <= RST_P1_PERIOD;
        end else if (wr_i && addr_i == ADDR_P1_PERIOD) begin
            p1_period_q <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            mirror_q <= RST_ZERO[5:0];
        end else if (wr_i && addr_i == ADDR_MIRROR) begin
            mirror_q <= wdata_i[5:0];
        end else if (wr_i && addr_i == ADDR_POLARITY && !config_q[CFG_BLOCK_POL_MIR_BIT]) begin
            mirror_q <= wdata_i[5:0];
        end
    end

    always_comb begin
        case (addr_i)
            ADDR_CONFIG: rdata_d = config_q;
            ADDR_LINK: rdata_d = {2'h0, link_q};
            ADDR_POLARITY: rdata_d = {2'h0, pol_q};
            ADDR_DRIVE: rdata_d = {2'h0, drive_q};
            ADDR_LINK_TRANS: rdata_d = {2'h0, ltran_q};
            ADDR_MIRROR: rdata_d = {2'h0, mirror_q};
            ADDR_ACTIVE: rdata_d = {2'h0, running};
            ADDR_BEH_LOW: rdata_d = beh_low_q;
            ADDR_BEH_HIGH: rdata_d = {4'h0, beh_high_q};
            ADDR_P1_PERIOD: rdata_d = p1_period_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= rdata_d;
        end else begin
            rdata_o <= 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            led_pin_o <= '1;
        end else begin
            led_pin_o <= pin_d;
        end
    end

    for (genvar i = 0; i < NUM_LED; i++) begin : g_ch
        ledb_run_t st_q;
        logic [11:0] pos_q;
        logic [11:0] per_q;
        logic [2:0] cnt_q;
        logic link_prev_q;
        logic [1:0] code;
        logic [6:0] units;
        logic [11:0] per_now;
        logic start;
        logic pulse_end;
        logic [11:0] half;
        logic [11:0] ramp_x;
        logic [19:0] scaled;
        logic [7:0] level;
        logic [7:0] duty;
        logic on;
        logic hold_now;

        assign code = codes[2*i +: 2];

        always_ff @(posedge clk_i) begin
            if (!nrst_i) begin
                hold_q[i] <= 1'b0;
                link_prev_q <= 1'b0;
            end else begin
                link_prev_q <= link_q[i];
                if (!link_q[i]) begin
                    hold_q[i] <= 1'b0;
                end else if (!link_prev_q && drive_q[i] && !touch_i[i] && ltran_q[i]) begin
                    hold_q[i] <= 1'b1;
                end
            end
        end

        // hold in the linking cycle too, so the pin never drops
        assign hold_now = hold_q[i] || (!link_prev_q && drive_q[i] && !touch_i[i] && ltran_q[i]);

        always_comb begin
            if (!link_q[i]) begin
                act[i] = drive_q[i];
            end else if (hold_now) begin
                act[i] = config_q[CFG_INVERTED_LINK_TRANSITION_BIT] ? !touch_i[i] : 1'b1;
            end else begin
                act[i] = touch_i[i];
            end
        end

        always_comb begin
            case (code)
                BEH_PULSE1: units = p1_period_q[P1_PERIOD_MSB:0];
                BEH_PULSE2: units = P2_PERIOD_UNITS;
                default: units = BR_PERIOD_UNITS;
            endcase
            if (units < MIN_PERIOD_UNITS) begin
                units = MIN_PERIOD_UNITS;
            end
            per_now = 12'(units) * PERIOD_UNIT_MS;
        end

        always_comb begin
            if (code == BEH_PULSE1 && p1_period_q[P1_START_TRIG_BIT]) begin
                start = act_q[i] && !act[i];
            end else begin
                start = !act_q[i] && act[i];
            end
        end

        assign pulse_end = tick && (pos_q == per_q - 12'h001);

        always_ff @(posedge clk_i) begin
            if (!nrst_i) begin
                st_q <= LEDB_IDLE;
                pos_q <= '0;
                per_q <= 12'h001;
                cnt_q <= '0;
                act_q[i] <= 1'b0;
            end else begin
                act_q[i] <= act[i];
                if (tick && st_q != LEDB_IDLE) begin
                    pos_q <= pulse_end ? 12'h000 : pos_q + 12'h001;
                end
                case (st_q)
                    LEDB_IDLE: begin
                        if (start) begin
                            st_q <= LEDB_RUN;
                            pos_q <= '0;
                            cnt_q <= '0;
                            per_q <= per_now;
                        end
                    end
                    LEDB_RUN: begin
                        case (code)
                            BEH_PULSE1: begin
                                if (pulse_end) begin
                                    cnt_q <= cnt_q + 3'h1;
                                    if (cnt_q == P1_PULSES_M1) begin
                                        st_q <= LEDB_IDLE;
                                    end
                                end
                            end
                            BEH_PULSE2: begin
                                if (!act[i]) begin
                                    st_q <= LEDB_TAIL;
                                    cnt_q <= '0;
                                end
                            end
                            default: begin
                                if (!act[i]) begin
                                    st_q <= LEDB_IDLE;
                                end
                            end
                        endcase
                    end
                    LEDB_TAIL: begin
                        if (pulse_end) begin
                            cnt_q <= cnt_q + 3'h1;
                            if (cnt_q == P2_PULSES_M1) begin
                                st_q <= LEDB_IDLE;
                            end
                        end
                    end
                    default: st_q <= LEDB_IDLE;
                endcase
            end
        end

        assign running[i] = (st_q != LEDB_IDLE);

        // triangle: each half of the period is one ramp
        always_comb begin
            half = per_q >> 1;
            ramp_x = (pos_q < half) ? pos_q : per_q - 12'h001 - pos_q;
            scaled = (20'(ramp_x) * 20'(DUTY_MAX - DUTY_MIN)) / 20'(half);
            level = DUTY_MIN + ((scaled > 20'(DUTY_MAX)) ? DUTY_MAX : scaled[7:0]);
        end

        always_comb begin
            if (code == BEH_DIRECT) begin
                duty = act[i] ? DUTY_MAX : DUTY_MIN;
            end else if (st_q == LEDB_IDLE) begin
                duty = DUTY_MIN;
            end else begin
                duty = level;
            end
            if (mirror_q[i]) begin
                duty = DUTY_MAX - duty;
            end
            on = (duty == DUTY_MAX) || (pwm_cnt_q < duty);
            // polarity zero drives low when on
            pin_d[i] = pol_q[i] ? on : !on;
        end
    end
endmodule

// ===== verif/ledb_engine_monitor.sv
// Purpose: Port checker for the LED behaviour engine
// Assumes: One clock, synchronous active-low reset
// Notes: Shadows only the config, mirror, polarity and period writes it needs, plus whether any write has occurred
`timescale 1ns/1ns
module ledb_engine_monitor #(
    parameter int MS_CYCLES = ledb_pkg::MS_CYCLES
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [ledb_pkg::NUM_LED-1:0] touch_i,
    input wire logic [7:0] rdata_o,
    input wire logic [ledb_pkg::NUM_LED-1:0] led_pin_o
);
    import ledb_pkg::*;
    logic blk_q, p1_wr_q, any_wr_q;
    logic [5:0] mir_q;
    logic mapped;
    assign mapped = addr_i inside {ADDR_CONFIG, ADDR_LINK, ADDR_POLARITY, ADDR_DRIVE,
        ADDR_LINK_TRANS, ADDR_MIRROR, ADDR_ACTIVE, ADDR_BEH_LOW, ADDR_BEH_HIGH, ADDR_P1_PERIOD};
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // Polarity writes copy into the mirror shadow unless blocked
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            blk_q <= 1'b0;
            p1_wr_q <= 1'b0;
            any_wr_q <= 1'b0;
            mir_q <= 6'h00;
        end else if (wr_i) begin
            any_wr_q <= 1'b1;
            if (addr_i == ADDR_CONFIG) blk_q <= wdata_i[CFG_BLOCK_POL_MIR_BIT];
            if (addr_i == ADDR_P1_PERIOD) p1_wr_q <= 1'b1;
            if (addr_i == ADDR_MIRROR || (addr_i == ADDR_POLARITY && !blk_q)) mir_q <= wdata_i[5:0];
        end
    end
    a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside its read cycle");
    a_reset_pins: assert property (disable iff (1'b0) !nrst_i |=> led_pin_o == 6'h3F)
        else $error("pins not off after reset");
    a_unmapped_zero: assert property (rd_i && !mapped |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_beh_high_rsv: assert property (rd_i && addr_i == ADDR_BEH_HIGH |=> rdata_o[7:4] == 4'h0)
        else $error("behaviour high upper bits set");
    a_ltran_rsv: assert property (rd_i && addr_i == ADDR_LINK_TRANS |=> rdata_o[7:6] == 2'h0)
        else $error("transition register upper bits set");
    a_p1_default: assert property (rd_i && addr_i == ADDR_P1_PERIOD && !p1_wr_q
        |=> rdata_o == RST_P1_PERIOD)
        else $error("pulse period reset value wrong");
    a_mirror_shadow: assert property (rd_i && addr_i == ADDR_MIRROR |=> rdata_o == {2'h0, mir_q})
        else $error("mirror bits do not follow writes");
    a_quiet_pins: assert property (!any_wr_q |-> led_pin_o == 6'h3F)
        else $error("pin moved before any register write");
    c_pol_write: cover property (wr_i && addr_i == ADDR_POLARITY);
    c_seq_busy: cover property (rd_i && addr_i == ADDR_ACTIVE ##1 rdata_o[0]);
    c_pin_lit: cover property (!led_pin_o[0] && touch_i[0]);
endmodule

// ===== verif/ledb_touch_model.sv
// Purpose: Touch sensing and LED load beside the engine
// Assumes: Touch levels are synchronous to the system clock
// Notes: Slow mode delays a touch change by two extra cycles
`timescale 1ns/1ns
module ledb_touch_model (
    input wire logic clk_i,
    input wire logic [5:0] press_i,
    input wire logic slow_i,
    input wire logic clr_i,
    input wire logic [5:0] led_pin_i,
    output logic [5:0] touch_o,
    output logic [15:0] lit_cnt_o
);
    logic [5:0] d1_q, d2_q;
    initial touch_o = 6'h00;
    initial lit_cnt_o = 16'h0000;
    always @(posedge clk_i) begin
        d1_q <= press_i;
        d2_q <= d1_q;
        touch_o <= slow_i ? d2_q : press_i;
        // Counts cycles where the first LED sinks current
        lit_cnt_o <= clr_i ? 16'h0000 : lit_cnt_o + {15'h0000, !led_pin_i[0]};
    end
endmodule

// ===== verif/test_ledb_engine.sv
// Purpose: Self-checking bench for the LED behaviour engine
// Assumes: Short millisecond tick of 10 clocks
// Notes: Table loop covers register fields, hand tests cover behaviour
`timescale 1ns/1ns
module test_ledb_engine;
    import ledb_pkg::*;
    typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} ledb_row_t;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, slow = 1'b0, clr = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [5:0] press = 6'h00, touch, led_pin;
    logic [15:0] lit;
    int miscompares = 0, samples_checked = 0;
    ledb_row_t rows [14] = '{'{1'b0, 8'h77, 8'h00, 8'h00}, '{1'b0, 8'h79, 8'h00, 8'h00},
        '{1'b0, 8'h81, 8'h00, 8'h00}, '{1'b0, 8'h82, 8'h00, 8'h00}, '{1'b0, 8'h84, 8'h00, 8'h20},
        '{1'b1, 8'h77, 8'hFF, 8'h3F}, '{1'b1, 8'h79, 8'h2A, 8'h2A}, '{1'b1, 8'h81, 8'hE4, 8'hE4},
        '{1'b1, 8'h82, 8'hFF, 8'h0F}, '{1'b1, 8'h84, 8'h85, 8'h85}, '{1'b1, 8'h90, 8'h55, 8'h00},
        '{1'b1, 8'h79, 8'h00, 8'h00}, '{1'b1, 8'h77, 8'h00, 8'h00}, '{1'b1, 8'h81, 8'h00, 8'h00}};
    always #50 clk = ~clk;
    ledb_engine #(.MS_CYCLES(10)) DUT (.clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .touch_i(touch), .rdata_o(rdata), .led_pin_o(led_pin));
    ledb_touch_model u_far (.clk_i(clk), .press_i(press), .slow_i(slow), .clr_i(clr),
        .led_pin_i(led_pin), .touch_o(touch), .lit_cnt_o(lit));
    task automatic close_out;
        if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_pin(input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH led_pin0 expected %b seen %b", e, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk_reg("rdata", e, rdata);
    endtask
    task automatic set_press(input logic p);
        @(posedge clk);
        press <= {5'h00, p};
    endtask
    task automatic pin_hold(input logic e);
        repeat (6) @(posedge clk);
        repeat (8) begin
            @(posedge clk);
            #1;
            chk_pin(e, led_pin[0]);
        end
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        close_out();
    end
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].e);
        end
        wr_reg(ADDR_DRIVE, 8'h01);
        pin_hold(1'b0);
        wr_reg(ADDR_DRIVE, 8'h00);
        pin_hold(1'b1);
        wr_reg(ADDR_DRIVE, 8'h01);
        wr_reg(ADDR_LINK, 8'h01);
        pin_hold(1'b1);
        set_press(1'b1);
        pin_hold(1'b0);
        wr_reg(ADDR_DRIVE, 8'h00);
        pin_hold(1'b0);
        slow <= 1'b1;
        set_press(1'b0);
        pin_hold(1'b1);
        slow <= 1'b0;
        wr_reg(ADDR_LINK, 8'h00);
        wr_reg(ADDR_LINK_TRANS, 8'h01);
        wr_reg(ADDR_DRIVE, 8'h01);
        wr_reg(ADDR_LINK, 8'h01);
        pin_hold(1'b0);
        set_press(1'b1);
        pin_hold(1'b0);
        set_press(1'b0);
        wr_reg(ADDR_LINK, 8'h00);
        wr_reg(ADDR_CONFIG, 8'h02);
        wr_reg(ADDR_LINK, 8'h01);
        pin_hold(1'b0);
        set_press(1'b1);
        pin_hold(1'b1);
        set_press(1'b0);
        wr_reg(ADDR_LINK, 8'h00);
        wr_reg(ADDR_CONFIG, 8'h00);
        wr_reg(ADDR_POLARITY, 8'h15);
        rd_chk(ADDR_MIRROR, 8'h15);
        wr_reg(ADDR_CONFIG, 8'h01);
        wr_reg(ADDR_POLARITY, 8'h00);
        rd_chk(ADDR_MIRROR, 8'h15);
        wr_reg(ADDR_CONFIG, 8'h00);
        wr_reg(ADDR_POLARITY, 8'h00);
        rd_chk(ADDR_MIRROR, 8'h00);
        wr_reg(ADDR_MIRROR, 8'h01);
        pin_hold(1'b1);
        wr_reg(ADDR_MIRROR, 8'h00);
        wr_reg(ADDR_DRIVE, 8'h00);
        wr_reg(ADDR_BEH_LOW, 8'h03);
        wr_reg(ADDR_DRIVE, 8'h01);
        rd_chk(ADDR_ACTIVE, 8'h01);
        wr_reg(ADDR_DRIVE, 8'h00);
        rd_chk(ADDR_ACTIVE, 8'h00);
        wr_reg(ADDR_BEH_LOW, 8'h02);
        wr_reg(ADDR_DRIVE, 8'h01);
        wr_reg(ADDR_DRIVE, 8'h00);
        rd_chk(ADDR_ACTIVE, 8'h01);
        repeat (6500) @(posedge clk);
        rd_chk(ADDR_ACTIVE, 8'h00);
        // Period code 0 runs at the 160 ms floor: 1600 clocks a pulse, five pulses
        wr_reg(ADDR_DRIVE, 8'h00);
        wr_reg(ADDR_BEH_LOW, 8'h01);
        wr_reg(ADDR_P1_PERIOD, 8'h00);
        wr_reg(ADDR_DRIVE, 8'h01);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (1600) @(posedge clk);
        chk_reg("pulse_lit", 8'h01, {7'h00, (lit > 16'd400 && lit < 16'd1200)});
        wr_reg(ADDR_DRIVE, 8'h00);
        wr_reg(ADDR_DRIVE, 8'h01);
        repeat (6280) @(posedge clk);
        rd_chk(ADDR_ACTIVE, 8'h01);
        repeat (200) @(posedge clk);
        rd_chk(ADDR_ACTIVE, 8'h00);
        repeat (100) @(posedge clk);
        rd_chk(ADDR_ACTIVE, 8'h00);
        wr_reg(ADDR_DRIVE, 8'h00);
        wr_reg(ADDR_P1_PERIOD, 8'h80);
        wr_reg(ADDR_DRIVE, 8'h01);
        rd_chk(ADDR_ACTIVE, 8'h00);
        wr_reg(ADDR_DRIVE, 8'h00);
        rd_chk(ADDR_ACTIVE, 8'h01);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        set_press(1'b1);
        rd_chk(ADDR_ACTIVE, 8'h00);
        pin_hold(1'b1);
        set_press(1'b0);
        close_out();
    end
endmodule
bind ledb_engine ledb_engine_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (.clk_i(clk_i),
    .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .touch_i(touch_i), .rdata_o(rdata_o), .led_pin_o(led_pin_o));
